//--- scl_defines.svh
// Purpose: Shared constants for the synthesizer control latches.
// Assumes: Included by bare name; definitions only.
// Notes: Bit positions count from the last bit shifted in.
`ifndef SCL_DEFINES_SVH
`define SCL_DEFINES_SVH

// ************************************************************
// Serial word and latch select
// ************************************************************
`define SCL_WORD_W 24
`define SCL_SEL_REF 2'h0
`define SCL_SEL_FB 2'h1
`define SCL_SEL_FUNC 2'h2
`define SCL_SEL_INIT 2'h3

// ************************************************************
// Function and startup latch fields
// ************************************************************
`define SCL_F_HOLD 2
`define SCL_F_PD_ARM 3
`define SCL_F_MON_LSB 4
`define SCL_F_MON_MSB 6
`define SCL_F_DET_POL 7
`define SCL_F_PUMP_TRI 8
`define SCL_F_FL_ON 9
`define SCL_F_FL_VAR 10
`define SCL_F_TO_LSB 11
`define SCL_F_TO_MSB 14
`define SCL_F_STEADY_LSB 15
`define SCL_F_STEADY_MSB 17
`define SCL_F_FAST_LSB 18
`define SCL_F_FAST_MSB 20
`define SCL_F_PD_SYNC 21
`define SCL_F_PRE_LSB 22
`define SCL_F_PRE_MSB 23
// Counter hold set, so dividers wait until software releases them
`define SCL_FUNC_RESET 24'h000004

// ************************************************************
// Reference and feedback divider latch fields
// ************************************************************
`define SCL_R_DIV_LSB 2
`define SCL_R_DIV_MSB 15
`define SCL_R_ABW_LSB 16
`define SCL_R_ABW_MSB 17
`define SCL_R_TEST_LSB 18
`define SCL_R_TEST_MSB 19
`define SCL_R_LOCK_PREC 20
`define SCL_B_SWAL_LSB 2
`define SCL_B_SWAL_MSB 7
`define SCL_B_MAIN_LSB 8
`define SCL_B_MAIN_MSB 20
`define SCL_B_TRIG 21

// ************************************************************
// Fastlock timeout
// ************************************************************
`define SCL_TO_STEP 4
`define SCL_TO_CNT_W 8

`endif

//--- scl_pkg.sv
// Purpose: Types for the synthesizer control latches.
// Assumes: Constants live in scl_defines.svh.
// Notes: Referenced only as scl_pkg::name.
package scl_pkg;
  // Programmed synchronous power-down progress
  typedef enum logic [1:0] {
    scl_pd_awake,
    scl_pd_pending,
    scl_pd_asleep
  } scl_pd_state_t;
endpackage : scl_pkg

//--- scl_sync3.sv
// Purpose: Three-flop synchroniser with agreement filter.
// Assumes: Input is asynchronous to clk_sys.
// Notes: Level changes once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module scl_sync3 (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // ************************************************************
  // Stages; the first is read only by the second
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Filtered level and one-cycle rise pulse
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      level_out <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      rise_out <= (s2_reg == s3_reg) && s3_reg && !level_out;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule : scl_sync3
`default_nettype wire

//--- scl_fastlock_timer.sv
// Purpose: Fastlock timeout counter, counted in pump events.
// Assumes: tick is a one-cycle pulse per phase detector cycle.
// Notes: Held at its load state whenever run is low.
`timescale 1ns/1ps
`default_nettype none
`include "scl_defines.svh"
module scl_fastlock_timer #(
  parameter int CNT_W = `SCL_TO_CNT_W,
  parameter int STEP = `SCL_TO_STEP
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic run,
  input wire logic tick,
  input wire logic [3:0] select,
  output logic expired
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] limit;

  // Period grows in equal steps with the select code
  assign limit = CNT_W'((int'(select) + 1) * STEP);

  // ************************************************************
  // Count pump events while running
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (reset || !run) begin
      count_reg <= '0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (tick && !expired) begin
        if (count_reg + CNT_W'(1) >= limit) begin
          count_reg <= '0;
          expired <= 1'b1;
        end else begin
          count_reg <= count_reg + CNT_W'(1);
        end
      end
    end
  end
endmodule : scl_fastlock_timer
`default_nettype wire

//--- scl_control_latches.sv
// Purpose: Serial control latches of a frequency synthesizer.
// Assumes: Host idles serial_clk while load_strobe is high.
// Notes: Shift register on serial_clk, latches on clk_sys.
//
// Notes on behaviour
// [R01] 24-bit word shifts in MSB first; strobe rise copies it to a latch.
// [R02] Two low bits pick reference, feedback, function or startup latch.
// [R03] Select code 10 writes the function latch.
// [R04] Counter hold bit at 2 keeps reference and feedback counters reset.
// [R05] Host clears counter hold after power-up to release dividers.
// [R06] Hold release frees both dividers on the same clock edge.
// [R07] Arm bit 3 and sync bit 21 act only while chip enable is high.
// [R08] Chip enable low powers down at once, whatever the bits hold.
// [R09] Arm 1 with sync 0 powers down immediately.
// [R10] Arm 1 with sync 1 waits for next pump event to power down; code also powers down on a counter reset pulse.
// [R11] Power-down loads counters, three-states pump, resets lock detect.
// [R12] Serial input keeps shifting and latching while powered down.
// [R13] Fastlock allowed only with fastlock-on bit 9 set.
// [R14] Variant bit 10: 0 manual exit, 1 timed exit.
// [R15] Writing trigger 1 in feedback latch enters fastlock, fast current.
// [R16] Variant one exits only on host writing trigger 0.
// [R17] Variant two timeout clears trigger and restores steady current.
// [R18] Timeout select is function bits 14 down to 11.
// [R19] Timeout counter runs only in variant two.
// [R20] Steady current bits 17:15, fast current bits 20:18.
// [R21] Host keeps prescaler output at or below 300 MHz.
// [R22] Monitor select bits 6:4 choose the monitor output.
// [R23] Startup load pulses counter reset; first feedback load repeats once.
// [R24] Pump three-state bit high three-states the pump, low enables; code also three-states it whenever counter hold is high.
// [R25] Reference latch: divider, antibacklash, test and lock precision.
// [R26] Feedback latch: swallow 7:2, main 20:8, trigger 21.
`timescale 1ns/1ps
`default_nettype none
`include "scl_defines.svh"
module scl_control_latches #(
  parameter int TO_STEP = `SCL_TO_STEP
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic chip_enable,
  input wire logic pump_event,
  input wire logic lock_detect_in,
  input wire logic ref_div_in,
  input wire logic fb_div_in,
  output logic counter_hold,
  output logic power_down,
  output logic pump_tristate,
  output logic lock_detect_reset,
  output logic [2:0] pump_current,
  output logic fastlock_active,
  output logic [1:0] prescaler_select,
  output logic detector_polarity,
  output logic monitor_output_pin,
  output logic [13:0] ref_div_value,
  output logic [1:0] antibacklash_width,
  output logic [1:0] test_bits,
  output logic lock_precision_bit,
  output logic [5:0] swallow_value,
  output logic [12:0] main_div_value,
  output logic fastlock_trigger_bit
);
  // ************************************************************
  // Declarations
  // ************************************************************
  logic [`SCL_WORD_W-1:0] shift_reg;
  logic [`SCL_WORD_W-1:0] func_reg;
  logic [1:0] sel;
  logic ld_level;
  logic ld_rise;
  logic ce_level;
  logic ce_rise;
  logic pump_rise;
  logic to_expired;
  logic init_armed_reg;
  logic reset_pulse_reg;
  logic write_fb;
  logic write_func;
  logic write_init;
  logic pd_arm;
  logic pd_sync;
  logic fl_on;
  logic fl_timed;
  logic hold_next;
  logic power_down_next;
  logic fl_active_next;
  scl_pkg::scl_pd_state_t pd_state_reg;

  // ************************************************************
  // Serial shift register on the link clock
  // ************************************************************
  // No reset here: the word is only data and keeps shifting always
  always_ff @(posedge serial_clk) begin
    shift_reg <= {shift_reg[`SCL_WORD_W-2:0], serial_data}; // R01 R12
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  scl_sync3 u_sync_load (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in(load_strobe),
    .level_out(ld_level),
    .rise_out(ld_rise)
  );

  scl_sync3 u_sync_ce (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in(chip_enable),
    .level_out(ce_level),
    .rise_out(ce_rise)
  );

  scl_sync3 u_sync_pump (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in(pump_event),
    .level_out(),
    .rise_out(pump_rise)
  );

  // ************************************************************
  // Latch select decode
  // ************************************************************
  // Word is stable across the crossing: serial_clk idles under strobe
  assign sel = shift_reg[1:0]; // R02
  assign write_fb = ld_rise && (sel == `SCL_SEL_FB); // R02
  assign write_func = ld_rise && (sel == `SCL_SEL_FUNC); // R03
  assign write_init = ld_rise && (sel == `SCL_SEL_INIT); // R23
  assign pd_arm = func_reg[`SCL_F_PD_ARM]; // R07
  assign pd_sync = func_reg[`SCL_F_PD_SYNC]; // R07
  assign fl_on = func_reg[`SCL_F_FL_ON]; // R13
  assign fl_timed = func_reg[`SCL_F_FL_VAR]; // R14

  // Function latch, also written by the startup latch
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      func_reg <= `SCL_FUNC_RESET;
    end else if (write_func || write_init) begin
      func_reg <= shift_reg; // R03 R23
    end
  end

  // Reference divider latch fields
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ref_div_value <= '0;
      antibacklash_width <= '0;
      test_bits <= '0;
      lock_precision_bit <= 1'b0;
    end else if (ld_rise && (sel == `SCL_SEL_REF)) begin
      ref_div_value <= shift_reg[`SCL_R_DIV_MSB:`SCL_R_DIV_LSB]; // R25
      antibacklash_width <= shift_reg[`SCL_R_ABW_MSB:`SCL_R_ABW_LSB];
      test_bits <= shift_reg[`SCL_R_TEST_MSB:`SCL_R_TEST_LSB];
      lock_precision_bit <= shift_reg[`SCL_R_LOCK_PREC];
    end
  end

  // Feedback divider values
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      swallow_value <= '0;
      main_div_value <= '0;
    end else if (write_fb) begin
      swallow_value <= shift_reg[`SCL_B_SWAL_MSB:`SCL_B_SWAL_LSB]; // R26
      main_div_value <= shift_reg[`SCL_B_MAIN_MSB:`SCL_B_MAIN_LSB];
    end
  end

  // ************************************************************
  // Fastlock trigger and timeout
  // ************************************************************
  // A host write beats a same-cycle timeout, so a new 1 is not lost
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fastlock_trigger_bit <= 1'b0;
    end else if (write_fb) begin
      fastlock_trigger_bit <= shift_reg[`SCL_B_TRIG]; // R15 R16
    end else if (to_expired) begin
      fastlock_trigger_bit <= 1'b0; // R17
    end
  end

  // Timer only in timed variant; power-down returns it to load state
  scl_fastlock_timer #(
    .CNT_W(`SCL_TO_CNT_W),
    .STEP(TO_STEP)
  ) u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(fl_on && fl_timed && fastlock_trigger_bit && !power_down), // R19 R11
    .tick(pump_rise),
    .select(func_reg[`SCL_F_TO_MSB:`SCL_F_TO_LSB]), // R18
    .expired(to_expired)
  );

  // ************************************************************
  // Startup reset pulse
  // ************************************************************
  // Armed by a startup load, spent by the first feedback load
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      init_armed_reg <= 1'b0;
      reset_pulse_reg <= 1'b0;
    end else begin
      reset_pulse_reg <= write_init || (write_fb && init_armed_reg); // R23
      if (write_init) begin
        init_armed_reg <= 1'b1;
      end else if (write_fb) begin
        init_armed_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Synchronous power-down sequencing
  // ************************************************************
  // Deferral keeps the loop from a frequency jump mid-cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pd_state_reg <= scl_pkg::scl_pd_awake;
    end else if (!(ce_level && pd_arm && pd_sync)) begin
      pd_state_reg <= scl_pkg::scl_pd_awake; // R07
    end else begin
      case (pd_state_reg)
        scl_pkg::scl_pd_awake: begin
          pd_state_reg <= scl_pkg::scl_pd_pending;
        end
        scl_pkg::scl_pd_pending: begin
          if (pump_rise || reset_pulse_reg) begin
            pd_state_reg <= scl_pkg::scl_pd_asleep; // R10
          end
        end
        scl_pkg::scl_pd_asleep: begin
          pd_state_reg <= scl_pkg::scl_pd_asleep;
        end
        default: begin
          pd_state_reg <= scl_pkg::scl_pd_awake;
        end
      endcase
    end
  end

  // ************************************************************
  // Control outputs
  // ************************************************************
  // Chip enable low wins over both programmed bits
  assign power_down_next = !ce_level // R08
    || (pd_arm && !pd_sync) // R09
    || (pd_state_reg == scl_pkg::scl_pd_asleep); // R10
  assign hold_next = func_reg[`SCL_F_HOLD] || reset_pulse_reg // R04 R23
    || power_down_next; // R11
  assign fl_active_next = fl_on && fastlock_trigger_bit; // R13 R15

  // One register drives both counters, so they leave hold together
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      power_down <= 1'b1;
      counter_hold <= 1'b1;
      pump_tristate <= 1'b1;
      lock_detect_reset <= 1'b1;
    end else begin
      power_down <= power_down_next;
      counter_hold <= hold_next; // R06
      pump_tristate <= func_reg[`SCL_F_PUMP_TRI] || hold_next; // R24 R11
      lock_detect_reset <= power_down_next; // R11
    end
  end

  // Pump current and programming fields
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pump_current <= '0;
      fastlock_active <= 1'b0;
      prescaler_select <= '0;
      detector_polarity <= 1'b0;
    end else begin
      fastlock_active <= fl_active_next;
      pump_current <= fl_active_next
        ? func_reg[`SCL_F_FAST_MSB:`SCL_F_FAST_LSB] // R15 R20
        : func_reg[`SCL_F_STEADY_MSB:`SCL_F_STEADY_LSB]; // R17 R20
      prescaler_select <= func_reg[`SCL_F_PRE_MSB:`SCL_F_PRE_LSB];
      detector_polarity <= func_reg[`SCL_F_DET_POL];
    end
  end

  // Monitor output multiplexer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      monitor_output_pin <= 1'b0;
    end else begin
      case (func_reg[`SCL_F_MON_MSB:`SCL_F_MON_LSB]) // R22
        3'h0: monitor_output_pin <= 1'b0;
        3'h1: monitor_output_pin <= lock_detect_in;
        3'h2: monitor_output_pin <= fb_div_in;
        3'h3: monitor_output_pin <= 1'b1;
        3'h4: monitor_output_pin <= ref_div_in;
        3'h5: monitor_output_pin <= ld_level;
        3'h6: monitor_output_pin <= power_down;
        default: monitor_output_pin <= fastlock_active;
      endcase
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_func_load: assert property ( // R03
    write_func |=> func_reg == $past(shift_reg))
    else $error("function latch not loaded");
  a_ce_low_pd: assert property ( // R08
    !ce_level |=> power_down && lock_detect_reset)
    else $error("chip enable low without power-down");
  a_async_pd: assert property ( // R09
    ce_level && pd_arm && !pd_sync |=> power_down)
    else $error("asynchronous power-down missing");
  a_pd_tristate: assert property ( // R11
    power_down |-> pump_tristate && counter_hold)
    else $error("power-down without pump three-state");
  a_hold_bit: assert property (func_reg[`SCL_F_HOLD] |=> counter_hold) // R04
    else $error("counter hold bit ignored");
  a_init_pulse: assert property ( // R23
    write_init |=> reset_pulse_reg ##1 counter_hold)
    else $error("startup load without reset pulse");
  a_first_fb: assert property ( // R23
    write_fb && init_armed_reg |=> reset_pulse_reg && !init_armed_reg)
    else $error("first feedback load missed pulse");
  a_sync_wait: assert property ( // R10
    pd_state_reg == scl_pkg::scl_pd_pending && !pump_rise
      && !reset_pulse_reg && ce_level
      |=> pd_state_reg != scl_pkg::scl_pd_asleep)
    else $error("synchronous power-down did not wait");
  a_manual_hold: assert property ( // R16
    fastlock_trigger_bit && !fl_timed && !write_fb
      |=> fastlock_trigger_bit)
    else $error("manual fastlock left without write");
  a_timeout_clr: assert property ( // R17
    to_expired && !write_fb |=> !fastlock_trigger_bit ##1
      pump_current == $past(func_reg[`SCL_F_STEADY_MSB:`SCL_F_STEADY_LSB]))
    else $error("timeout did not restore steady current");
  a_fast_cur: assert property ( // R20
    fastlock_active
      |-> pump_current == $past(func_reg[`SCL_F_FAST_MSB:`SCL_F_FAST_LSB]))
    else $error("fast current not applied");

  c_init_then_fb: cover property (write_init ##[1:200] write_fb);
  c_timeout: cover property (to_expired);
  c_sync_sleep: cover property (pd_state_reg == scl_pkg::scl_pd_pending
    ##1 pd_state_reg == scl_pkg::scl_pd_asleep);
  c_ce_return: cover property (ce_rise ##[1:20] !power_down);
endmodule : scl_control_latches
`default_nettype wire

//--- scl_host_model.sv
// Purpose: Host side of the three-wire serial write link.
// Assumes: Serial clock idles low between frames.
// Notes: Data line shows the inverse of its last bit once released.
`timescale 1ns/1ps
`default_nettype none
module scl_host_model (
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe
);
  // ********************
  // Idle levels
  // ********************
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  // One frame of 24 bits, MSB first, then the strobe pulse
  task automatic send_word(input logic [23:0] x);
    for (int i = 23; i >= 0; i--) begin
      serial_data = x[i];
      #16 serial_clk = 1'b1;
      #16 serial_clk = 1'b0;
    end
    // Released line must not keep showing a valid bit
    serial_data = ~x[0];
    #16 load_strobe = 1'b1;
    // Clock stays still while the word crosses into the latch domain
    #400 load_strobe = 1'b0;
    #400;
  endtask : send_word
endmodule : scl_host_model
`default_nettype wire

//--- scl_control_latches_test.sv
// Purpose: Self-checking bench for the synthesizer control latches.
// Assumes: Timeout step shortened to one pump event.
// Notes: Random fields from a fixed seed, corner cases by hand.
`timescale 1ns/1ps
`default_nettype none
`include "scl_defines.svh"
module scl_control_latches_test;
  logic clk_sys, reset, chip_enable, pump_event;
  logic lock_detect_in, ref_div_in, fb_div_in;
  logic serial_clk, serial_data, load_strobe;
  logic counter_hold, power_down, pump_tristate, lock_detect_reset;
  logic fastlock_active, detector_polarity, monitor_output_pin;
  logic lock_precision_bit, fastlock_trigger_bit;
  logic [2:0] pump_current;
  logic [1:0] prescaler_select, antibacklash_width, test_bits;
  logic [13:0] ref_div_value;
  logic [5:0] swallow_value;
  logic [12:0] main_div_value;
  logic [23:0] fw, w;
  int err_total, n_compared, seed, hp, hp0;

  // Short timeout step keeps fastlock runs brief
  scl_control_latches #(.TO_STEP(1)) u_dut (.clk_sys, .reset,
    .serial_clk, .serial_data, .load_strobe, .chip_enable, .pump_event,
    .lock_detect_in, .ref_div_in, .fb_div_in, .counter_hold, .power_down,
    .pump_tristate, .lock_detect_reset, .pump_current, .fastlock_active,
    .prescaler_select, .detector_polarity, .monitor_output_pin,
    .ref_div_value, .antibacklash_width, .test_bits, .lock_precision_bit,
    .swallow_value, .main_div_value, .fastlock_trigger_bit);
  scl_host_model u_host (.serial_clk, .serial_data, .load_strobe);

  // ********************
  // Clock and helpers
  // ********************
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Counts hold cycles, so short counter-reset pulses are seen
  always @(posedge clk_sys) begin
    if (reset) begin
      hp <= 0;
    end else if (counter_hold === 1'b1) begin
      hp <= hp + 1;
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask : cyc

  task automatic wr(input logic [23:0] x);
    cyc(1);
    u_host.send_word(x);
    cyc(2);
  endtask : wr

  task automatic pulse(input int n);
    repeat (n) begin
      pump_event = 1'b1;
      cyc(4);
      pump_event = 1'b0;
      cyc(4);
    end
  endtask : pulse

  // Function word; c is {hold, arm, sync, fastlock on, variant}
  function automatic logic [23:0] mkf(input logic [4:0] c,
                                      input logic [3:0] t,
                                      input logic [2:0] m);
    logic [23:0] f;
    f = 24'($random(seed));
    f[1:0] = `SCL_SEL_FUNC;
    {f[2], f[3], f[21], f[9], f[10]} = c;
    f[14:11] = t;
    f[6:4] = m;
    return f;
  endfunction : mkf

  function automatic logic mon_exp(input logic [2:0] m);
    case (m)
      3'h1: return lock_detect_in;
      3'h2: return fb_div_in;
      3'h3: return 1'b1;
      3'h4: return ref_div_in;
      default: return 1'b0;
    endcase
  endfunction : mon_exp

  // Outputs derived from the function latch
  task automatic chkf(input logic trig, input logic pd);
    logic fast;
    fast = fw[9] & trig;
    chk(24'(fastlock_active), 24'(fast));
    chk(24'(pump_current), 24'(fast ? fw[20:18] : fw[17:15]));
    chk(24'(counter_hold), 24'(fw[2] | pd));
    chk(24'(power_down), 24'(pd));
    chk(24'(lock_detect_reset), 24'(pd));
    chk(24'(pump_tristate), 24'(fw[8] | fw[2] | pd));
    chk(24'(prescaler_select), 24'(fw[23:22]));
    chk(24'(detector_polarity), 24'(fw[7]));
  endtask : chkf

  task automatic wb(input logic t);
    w = 24'($random(seed));
    w[21] = t;
    w[1:0] = `SCL_SEL_FB;
    wr(w);
    chk(24'(swallow_value), 24'(w[7:2]));
    chk(24'(main_div_value), 24'(w[20:8]));
    chk(24'(fastlock_trigger_bit), 24'(t));
  endtask : wb

  task automatic wref;
    w = 24'($random(seed));
    w[1:0] = `SCL_SEL_REF;
    wr(w);
    chk(24'(ref_div_value), 24'(w[15:2]));
    chk(24'(antibacklash_width), 24'(w[17:16]));
    chk(24'(test_bits), 24'(w[19:18]));
    chk(24'(lock_precision_bit), 24'(w[20]));
  endtask : wref

  // ********************
  // Main sequence
  // ********************
  initial begin
    seed = 26;
    err_total = 0;
    n_compared = 0;
    {reset, chip_enable, pump_event} = 3'h6;
    {lock_detect_in, ref_div_in, fb_div_in} = 3'h0;
    repeat (10) @(posedge clk_sys);
    #5 reset = 1'b0;
    cyc(8);
    // Startup word with hold released, then two feedback loads
    fw = mkf(5'h00, 4'h0, 3'h0);
    fw[1:0] = `SCL_SEL_INIT;
    wr(fw);
    chkf(1'b0, 1'b0);
    hp0 = hp;
    wb(1'b0);
    chk(24'(hp - hp0), 24'h1);
    wb(1'b0);
    chk(24'(hp - hp0), 24'h1);
    for (int i = 0; i < 3; i++) wref();
    fw = mkf(5'h10, 4'h0, 3'h0);
    wr(fw);
    chkf(1'b0, 1'b0);
    for (int m = 0; m < 8; m++) begin
      fw = mkf(5'h00, 4'h0, 3'(m));
      wr(fw);
      {lock_detect_in, ref_div_in, fb_div_in} = 3'($random(seed));
      cyc(4);
      chk(24'(monitor_output_pin), 24'(mon_exp(3'(m))));
    end
    // Both fastlock variants; timeout select 2 means three events
    for (int v = 0; v < 2; v++) begin
      fw = mkf({4'h1, v[0]}, 4'h2, 3'h0);
      wr(fw);
      wb(1'b1);
      chkf(1'b1, 1'b0);
      pulse(2);
      chk(24'(fastlock_active), 24'h1);
      pulse(1);
      cyc(4);
      chk(24'(fastlock_trigger_bit), 24'(v == 0));
      chkf(v == 0, 1'b0);
      wb(1'b0);
      chkf(1'b0, 1'b0);
    end
    // Trigger without fastlock on keeps steady current
    fw = mkf(5'h00, 4'h0, 3'h0);
    wr(fw);
    wb(1'b1);
    chkf(1'b1, 1'b0);
    wb(1'b0);
    // Immediate, deferred and pin power-down
    fw = mkf(5'h08, 4'h0, 3'h0);
    wr(fw);
    chkf(1'b0, 1'b1);
    wref();
    fw = mkf(5'h00, 4'h0, 3'h0);
    wr(fw);
    chkf(1'b0, 1'b0);
    fw = mkf(5'h0C, 4'h0, 3'h0);
    wr(fw);
    chkf(1'b0, 1'b0);
    pulse(1);
    chkf(1'b0, 1'b1);
    fw = mkf(5'h00, 4'h0, 3'h0);
    wr(fw);
    chip_enable = 1'b0;
    cyc(8);
    chkf(1'b0, 1'b1);
    fw = mkf(5'h00, 4'h0, 3'h0);
    wr(fw);
    chkf(1'b0, 1'b1);
    chip_enable = 1'b1;
    cyc(8);
    chkf(1'b0, 1'b0);
    tally_and_finish();
  end

  // About thirty frames of 1.6 us each; a wide margin on top
  initial begin
    #500000;
    err_total++;
    tally_and_finish();
  end
endmodule : scl_control_latches_test
`default_nettype wire
